// ---- logic/sai_top.sv ----
/*
  Register block of an eight-channel safe analog I/O module family:
  resistance input readings and status word, current input readings and
  broken-wire status, output setpoints with time-out behaviour, reached
  over APB. Assumes field inputs are synchronous to pclk and that raw
  readings arrive normalised so that 16'hFFFF is the range maximum.
*/
// Functional notes
// - In resistance mode the input side offers nine contiguous input words.
// - Input words one to eight carry the reading of the channel of the same number.
// - The ninth input word is a 16-bit status word with per-channel faults.
// - Each channel has a status bit set while its wire is open or it is out of range.
// - Each channel has a separate range-warning bit.
// - Every channel is configured on its own: enable, wiring style, sensor type.
// - The current-input side offers nine contiguous input words.
// - A broken-wire bit is set when any live-zero current channel has a broken wire.
// - Live-zero current reads as 0..16000 or 0..4095 as selected.
// - Zero-based current reads 0..20000 for 20 mA and 0..25000 for 25 mA.
// - The output side offers eight contiguous setpoint words, one per channel.
// - Each output channel takes the same selectable range scalings.
// - Outputs enter their time-out state once the controller stops controlling.
// - Time-out per channel holds the last value, drives a user value, or disables.
`timescale 1ns/1ps

module sai_top #(
  parameter int NCH = sai_pkg::NCH,
  parameter int WD_CYCLES = sai_pkg::WD_CYCLES
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Resistance input front end
  input wire logic [NCH*16-1:0] rtd_raw,
  input wire logic [NCH-1:0] rtd_fault_in,
  input wire logic [NCH-1:0] rtd_warn_in,
  output logic [NCH-1:0] rtd_ch_enable,
  output logic [NCH*2-1:0] rtd_wiring,
  output logic [NCH*4-1:0] rtd_sensor,
  // Current input front end
  input wire logic [NCH*16-1:0] cur_raw,
  input wire logic [NCH-1:0] cur_broken_in,
  // Output drivers
  output logic [NCH*16-1:0] dac_code,
  output logic [NCH-1:0] dac_enable,
  output logic timeout_active
);

  if (NCH != 8) begin : g_chk_nch
    $error("sai_top supports exactly eight channels");
  end
  if (WD_CYCLES < 2) begin : g_chk_wd
    $error("sai_top watchdog count too small");
  end

  // Full scale of a range code
  function automatic logic [15:0] fs_of(input logic [1:0] rng);
    logic [15:0] f;
    f = sai_pkg::FS_LZ_16K;
    case (sai_pkg::sai_range_type'(rng))
      sai_pkg::RNG_LZ_16K: f = sai_pkg::FS_LZ_16K;
      sai_pkg::RNG_LZ_4095: f = sai_pkg::FS_LZ_4095;
      sai_pkg::RNG_Z20: f = sai_pkg::FS_Z20;
      sai_pkg::RNG_Z25: f = sai_pkg::FS_Z25;
      default: f = sai_pkg::FS_LZ_16K;
    endcase
    return f;
  endfunction

  // Rounded linear map of a normalised reading onto 0..fs
  // Full 32-bit product: a 16-bit product would wrap at every range
  function automatic logic [15:0] scale(input logic [15:0] raw, input logic [15:0] fs);
    logic [31:0] prod;
    logic [32:0] p;
    prod = {16'h0000, raw} * {16'h0000, fs};
    p = {1'b0, prod} + 33'h0_0000_8000;
    return p[31:16];
  endfunction

  // APB decode
  logic [3:0] region;
  logic [2:0] chan;
  logic addr_ok;
  logic [31:0] rd_val;
  logic rd_err;
  logic wr_ro;
  logic wr_fire;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // Control and state
  logic rtd_mode_r;
  logic host_run_r;
  sai_pkg::sai_state_type state_r;
  sai_pkg::sai_state_type state_nxt;
  logic [31:0] wd_cnt_r;
  logic sp_write;

  // Per-channel storage
  logic [15:0] cfg_r [NCH];
  logic [15:0] sp_r [NCH];
  logic [13:0] tov_r [NCH];
  logic [15:0] rtd_rd_r [NCH];
  logic [15:0] cur_rd_r [NCH];
  logic [15:0] dac_r [NCH];
  logic [NCH-1:0] dac_en_r;
  logic [15:0] rtd_stat_r;
  logic cur_broken_r;
  logic [NCH-1:0] broken_lz;

  assign region = paddr[8:5];
  assign chan = paddr[4:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:9] == 3'b000);
  assign wr_fire = psel && penable && pready_r && pwrite && !pslverr_r;
  assign sp_write = wr_fire && (region == sai_pkg::OUT_SP_BASE[8:5]);

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    wr_ro = 1'b0;
    case (region)
      sai_pkg::RTD_RD_BASE[8:5]: begin
        rd_val = {16'h0000, rtd_rd_r[chan]};
        wr_ro = 1'b1;
      end
      sai_pkg::RTD_STAT[8:5]: begin
        rd_err = (chan != 3'h0);
        rd_val = {16'h0000, rtd_stat_r};
        wr_ro = 1'b1;
      end
      sai_pkg::CUR_RD_BASE[8:5]: begin
        rd_val = {16'h0000, cur_rd_r[chan]};
        wr_ro = 1'b1;
      end
      sai_pkg::CUR_STAT[8:5]: begin
        rd_err = (chan != 3'h0);
        rd_val[sai_pkg::CUR_BROKEN_POS] = cur_broken_r;
        wr_ro = 1'b1;
      end
      sai_pkg::OUT_SP_BASE[8:5]: rd_val = {16'h0000, sp_r[chan]};
      sai_pkg::CH_CFG_BASE[8:5]: rd_val = {16'h0000, cfg_r[chan]};
      sai_pkg::TO_VAL_BASE[8:5]: rd_val = {18'h0_0000, tov_r[chan]};
      sai_pkg::CTRL[8:5]: begin
        rd_err = (chan != 3'h0);
        rd_val[sai_pkg::CTRL_RTD_POS] = rtd_mode_r;
        rd_val[sai_pkg::CTRL_RUN_POS] = host_run_r;
        rd_val[sai_pkg::CTRL_STATE_POS +: 2] = state_r;
      end
      default: rd_err = 1'b1;
    endcase
    if (!addr_ok) begin
      rd_err = 1'b1;
    end
  end

  // Answer in the setup cycle so the access phase completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= (pwrite || rd_err) ? 32'h0000_0000 : rd_val;
      pready_r <= 1'b1;
      pslverr_r <= rd_err || (pwrite && wr_ro);
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtd_mode_r <= sai_pkg::CTRL_RESET[sai_pkg::CTRL_RTD_POS];
      host_run_r <= sai_pkg::CTRL_RESET[sai_pkg::CTRL_RUN_POS];
    end else if (wr_fire && region == sai_pkg::CTRL[8:5]) begin
      rtd_mode_r <= pwdata[sai_pkg::CTRL_RTD_POS];
      host_run_r <= pwdata[sai_pkg::CTRL_RUN_POS];
    end
  end

  // Watchdog restarts on every setpoint write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= 32'h0000_0000;
    end else if (sp_write || state_r != sai_pkg::ST_RUN) begin
      wd_cnt_r <= 32'h0000_0000;
    end else if (wd_cnt_r != 32'(WD_CYCLES - 1)) begin
      wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sai_pkg::ST_IDLE: begin
        if (sp_write && host_run_r) begin
          state_nxt = sai_pkg::ST_RUN;
        end
      end
      sai_pkg::ST_RUN: begin
        if (!host_run_r || wd_cnt_r == 32'(WD_CYCLES - 1)) begin
          state_nxt = sai_pkg::ST_TIMEOUT;
        end
      end
      sai_pkg::ST_TIMEOUT: begin
        if (sp_write && host_run_r) begin
          state_nxt = sai_pkg::ST_RUN;
        end
      end
      default: state_nxt = sai_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sai_pkg::ST_IDLE;
      timeout_active <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timeout_active <= (state_nxt == sai_pkg::ST_TIMEOUT);
    end
  end

  // Status follows live conditions, so it clears without software
  // Gated by the live enable so a disabled channel never reports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtd_stat_r <= 16'h0000;
    end else begin
      rtd_stat_r <= {rtd_warn_in & rtd_ch_enable, rtd_fault_in & rtd_ch_enable};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_broken_r <= 1'b0;
    end else begin
      cur_broken_r <= |broken_lz;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [1:0] irng;
    logic [1:0] orng;
    logic [15:0] ofs;
    logic [15:0] sp_clip;
    logic [13:0] pct;
    logic [29:0] user_prod;
    logic [15:0] user_code;

    assign irng = cfg_r[i][sai_pkg::CFG_IRNG_POS +: 2];
    assign orng = cfg_r[i][sai_pkg::CFG_ORNG_POS +: 2];
    assign ofs = fs_of(orng);
    assign sp_clip = (sp_r[i] > ofs) ? ofs : sp_r[i];
    assign pct = (tov_r[i] > sai_pkg::PCT_FULL) ? sai_pkg::PCT_FULL : tov_r[i];
    assign user_prod = 30'(pct * ofs);
    assign user_code = 16'(user_prod / 30'(sai_pkg::PCT_FULL));
    // Live-zero ranges are codes 00 and 01
    assign broken_lz[i] = cur_broken_in[i] && !irng[1];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_r[i] <= sai_pkg::CFG_RESET;
      end else if (wr_fire && chan == 3'(i) && region == sai_pkg::CH_CFG_BASE[8:5]) begin
        cfg_r[i] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sp_r[i] <= 16'h0000;
      end else if (sp_write && chan == 3'(i)) begin
        sp_r[i] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tov_r[i] <= 14'h0000;
      end else if (wr_fire && chan == 3'(i) && region == sai_pkg::TO_VAL_BASE[8:5]) begin
        tov_r[i] <= pwdata[13:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rtd_rd_r[i] <= 16'h0000;
      end else begin
        rtd_rd_r[i] <= (rtd_mode_r && cfg_r[i][sai_pkg::CFG_EN_POS]) ? rtd_raw[i*16 +: 16] : 16'h0000;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cur_rd_r[i] <= 16'h0000;
      end else begin
        cur_rd_r[i] <= scale(cur_raw[i*16 +: 16], fs_of(irng));
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dac_r[i] <= 16'h0000;
        dac_en_r[i] <= 1'b0;
      end else begin
        case (state_nxt)
          sai_pkg::ST_RUN: begin
            dac_r[i] <= sp_clip;
            dac_en_r[i] <= 1'b1;
          end
          sai_pkg::ST_TIMEOUT: begin
            case (sai_pkg::sai_tomode_type'(cfg_r[i][sai_pkg::CFG_TO_POS +: 2]))
              sai_pkg::TO_LAST: begin
                dac_r[i] <= dac_r[i];
              end
              sai_pkg::TO_USER: begin
                dac_r[i] <= user_code;
                dac_en_r[i] <= 1'b1;
              end
              default: begin
                dac_r[i] <= 16'h0000;
                dac_en_r[i] <= 1'b0;
              end
            endcase
          end
          default: begin
            dac_r[i] <= 16'h0000;
            dac_en_r[i] <= 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rtd_ch_enable[i] <= 1'b0;
        rtd_wiring[i*2 +: 2] <= 2'h0;
        rtd_sensor[i*4 +: 4] <= 4'h0;
      end else begin
        rtd_ch_enable[i] <= cfg_r[i][sai_pkg::CFG_EN_POS] && rtd_mode_r;
        rtd_wiring[i*2 +: 2] <= cfg_r[i][sai_pkg::CFG_WIRE_POS +: 2];
        rtd_sensor[i*4 +: 4] <= cfg_r[i][sai_pkg::CFG_SENS_POS +: 4];
      end
    end

    // Extra stage keeps the output pins straight off a flop
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dac_code[i*16 +: 16] <= 16'h0000;
      end else begin
        dac_code[i*16 +: 16] <= dac_r[i];
      end
    end
  end

  always_comb begin
    dac_enable = dac_en_r;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule

// ---- logic/sai_pkg.sv ----
/*
  Shared constants of the safe analog I/O register block: register map,
  field positions, reset values, range and time-out encodings, timing.
  Assumes a 20 MHz pclk and a 12-bit APB byte address.
*/
package sai_pkg;

  localparam int NCH = 8;
  localparam int CLK_HZ = 20_000_000;

  // Byte addresses; channel registers step by one word
  localparam logic [11:0] RTD_RD_BASE = 12'h000;
  localparam logic [11:0] RTD_STAT = 12'h020;
  localparam logic [11:0] CUR_RD_BASE = 12'h040;
  localparam logic [11:0] CUR_STAT = 12'h060;
  localparam logic [11:0] OUT_SP_BASE = 12'h080;
  localparam logic [11:0] CH_CFG_BASE = 12'h0C0;
  localparam logic [11:0] TO_VAL_BASE = 12'h0E0;
  localparam logic [11:0] CTRL = 12'h100;

  // Channel configuration fields
  localparam int CFG_EN_POS = 0;
  localparam int CFG_WIRE_POS = 1;
  localparam int CFG_SENS_POS = 3;
  localparam int CFG_IRNG_POS = 8;
  localparam int CFG_ORNG_POS = 10;
  localparam int CFG_TO_POS = 12;
  localparam logic [15:0] CFG_RESET = 16'h0001;

  // Control fields
  localparam int CTRL_RTD_POS = 0;
  localparam int CTRL_RUN_POS = 1;
  localparam int CTRL_STATE_POS = 2;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status word layout
  localparam int STAT_FAULT_POS = 0;
  localparam int STAT_WARN_POS = 8;
  localparam int CUR_BROKEN_POS = 0;

  // Full-scale codes
  localparam logic [15:0] FS_LZ_16K = 16'h3E80;
  localparam logic [15:0] FS_LZ_4095 = 16'h0FFF;
  localparam logic [15:0] FS_Z20 = 16'h4E20;
  localparam logic [15:0] FS_Z25 = 16'h61A8;
  localparam logic [13:0] PCT_FULL = 14'h2710;

  // Loss-of-control watchdog
  localparam int WD_TIME_MS = 100;
  localparam int WD_CYCLES = WD_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    RNG_LZ_16K = 2'b00,
    RNG_LZ_4095 = 2'b01,
    RNG_Z20 = 2'b10,
    RNG_Z25 = 2'b11
  } sai_range_type;

  typedef enum logic [1:0] {
    TO_LAST = 2'b00,
    TO_USER = 2'b01,
    TO_OFF = 2'b10,
    TO_OFF2 = 2'b11
  } sai_tomode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TIMEOUT = 2'b11
  } sai_state_type;

endpackage

// ---- dv/sai_top_chk_props.sv ----
/*
  Port checker for sai_top, bound to every instance.
  Assumes zero-wait APB and WD_CYCLES handed on by the bind.
*/
`timescale 1ns/1ps
module sai_top_chk #(
  parameter int NCH = 8,
  parameter int WD_CYCLES = 50
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Field side
  input wire logic [NCH-1:0] rtd_ch_enable,
  input wire logic [NCH*16-1:0] dac_code,
  input wire logic [NCH-1:0] dac_enable,
  input wire logic timeout_active
);
  logic wr;
  logic exit_wr;
  assign wr = psel && penable && pwrite;
  // Setpoint and control writes may legally end a time-out
  assign exit_wr = wr && pready && (paddr[11:5] == sai_pkg::OUT_SP_BASE[11:5] || paddr == sai_pkg::CTRL);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_only_access: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  chk_off_code_zero: assert property (!dac_enable[0] && !$past(dac_enable[0]) |-> dac_code[15:0] == 16'h0000)
    else $error("disabled output carries a code");
  chk_code_span: assert property (dac_code[15:0] <= sai_pkg::FS_Z25)
    else $error("output code above span");
  chk_timeout_sticky: assert property (
    timeout_active && !exit_wr && !$past(exit_wr) && !$past(exit_wr, 2) |=> timeout_active)
    else $error("time-out left without host action");
  chk_chan_en_stable: assert property (
    $past(presetn) && !wr && !$past(wr) |=> $stable(rtd_ch_enable))
    else $error("channel enable moved without a write");

  cover property (exit_wr);
  cover property ($rose(timeout_active));
  cover property (pready && pslverr);
endmodule

bind sai_top sai_top_chk #(.NCH(NCH), .WD_CYCLES(WD_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rtd_ch_enable(rtd_ch_enable), .dac_code(dac_code), .dac_enable(dac_enable),
  .timeout_active(timeout_active)
);

// ---- dv/sai_ctl_model.sv ----
/*
  Controller model: APB master that exchanges the I/O map words.
  Assumes xfer is entered just after a rising pclk edge.
*/
`timescale 1ns/1ps
module sai_ctl_model (
  // APB master side
  input wire logic pclk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale write data must not look valid
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// ---- dv/sai_top_tb.sv ----
/*
  Self-checking bench for sai_top with a shortened watchdog.
  Assumes the controller model drives APB and the bench the field inputs.
*/
`timescale 1ns/1ps
module sai_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [127:0] rtd_raw = '0, cur_raw = '0, dac_code;
  logic [7:0] rtd_fault_in = '0, rtd_warn_in = '0, cur_broken_in = '0, rtd_ch_enable, dac_enable;
  logic [15:0] rtd_wiring;
  logic [31:0] rtd_sensor;
  logic timeout_active;
  logic [15:0] fs [4] = '{sai_pkg::FS_LZ_16K, sai_pkg::FS_LZ_4095, sai_pkg::FS_Z20, sai_pkg::FS_Z25};
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 pclk = ~pclk;

  sai_top #(.WD_CYCLES(50)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtd_raw(rtd_raw), .rtd_fault_in(rtd_fault_in), .rtd_warn_in(rtd_warn_in),
    .rtd_ch_enable(rtd_ch_enable), .rtd_wiring(rtd_wiring), .rtd_sensor(rtd_sensor),
    .cur_raw(cur_raw), .cur_broken_in(cur_broken_in), .dac_code(dac_code),
    .dac_enable(dac_enable), .timeout_active(timeout_active)
  );

  sai_ctl_model host_u (
    .pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic t_rtd;
    for (int i = 0; i < 8; i++) begin
      rtd_raw[16*i +: 16] <= 16'h0A00 + 16'(i);
    end
    rtd_fault_in <= 8'hA5;
    rtd_warn_in <= 8'h3C;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      host_u.xfer(1'b0, 12'(4 * i), 32'h0, q, e);
      chk("rtd_reading", 32'h0A00 + i, q);
    end
    host_u.xfer(1'b0, sai_pkg::RTD_STAT, 32'h0, q, e);
    chk("rtd_status", 32'h0000_3CA5, q);
    host_u.xfer(1'b0, 12'h024, 32'h0, q, e);
    chk("rtd_tenth_word", 32'h1, e);
    host_u.xfer(1'b1, sai_pkg::RTD_RD_BASE, 32'h1, q, e);
    chk("rtd_ro_write", 32'h1, e);
    rtd_fault_in <= 8'h00;
    rtd_warn_in <= 8'h00;
    repeat (2) @(posedge pclk);
    host_u.xfer(1'b0, sai_pkg::RTD_STAT, 32'h0, q, e);
    chk("rtd_status_clear", 32'h0, q);
    // Channel 2 off, 3-wire style, sensor code 5
    host_u.xfer(1'b1, sai_pkg::CH_CFG_BASE + 12'h004, 32'h0000_002C, q, e);
    repeat (2) @(posedge pclk);
    host_u.xfer(1'b0, 12'h004, 32'h0, q, e);
    chk("rtd_off_reading", 32'h0, q);
    chk("chan_enable", 32'hFD, rtd_ch_enable);
    chk("wiring", 32'h2, rtd_wiring[3:2]);
    chk("sensor", 32'h5, rtd_sensor[7:4]);
    // Resistance mode off: readings and enables drop
    host_u.xfer(1'b1, sai_pkg::CTRL, 32'h0, q, e);
    repeat (2) @(posedge pclk);
    host_u.xfer(1'b0, sai_pkg::RTD_RD_BASE, 32'h0, q, e);
    chk("rtd_mode_off", 32'h0, q);
    chk("mode_off_enable", 32'h0, rtd_ch_enable);
    host_u.xfer(1'b1, sai_pkg::CTRL, 32'h1, q, e);
  endtask

  task automatic t_cur;
    cur_raw <= {8{16'hFFFF}};
    cur_broken_in <= 8'h01;
    for (int r = 0; r < 4; r++) begin
      host_u.xfer(1'b1, sai_pkg::CH_CFG_BASE, {22'h0, 2'(r), 8'h01}, q, e);
      repeat (2) @(posedge pclk);
      host_u.xfer(1'b0, sai_pkg::CUR_RD_BASE, 32'h0, q, e);
      chk("cur_full", fs[r], q);
      host_u.xfer(1'b0, sai_pkg::CUR_STAT, 32'h0, q, e);
      chk("cur_broken", (r < 2), q);
    end
    host_u.xfer(1'b0, sai_pkg::CUR_RD_BASE + 12'h01C, 32'h0, q, e);
    chk("cur_ch8", sai_pkg::FS_LZ_16K, q);
    cur_raw[15:0] <= 16'h8000;
    repeat (2) @(posedge pclk);
    host_u.xfer(1'b0, sai_pkg::CUR_RD_BASE, 32'h0, q, e);
    chk("cur_half", sai_pkg::FS_Z25 / 2, q);
  endtask

  task automatic t_out;
    host_u.xfer(1'b1, sai_pkg::CTRL, 32'h3, q, e);
    for (int r = 0; r < 4; r++) begin
      host_u.xfer(1'b1, sai_pkg::CH_CFG_BASE, {18'h0, 2'b01, 2'(r), 10'h001}, q, e);
      host_u.xfer(1'b1, sai_pkg::OUT_SP_BASE, 32'd30000, q, e);
      repeat (3) @(posedge pclk);
      chk("out_clamp", fs[r], dac_code[15:0]);
      chk("out_en", 32'h1, dac_enable[0]);
    end
    host_u.xfer(1'b1, sai_pkg::OUT_SP_BASE + 12'h01C, 32'd12345, q, e);
    repeat (3) @(posedge pclk);
    chk("out_ch8", 32'd12345, dac_code[127:112]);
    host_u.xfer(1'b1, sai_pkg::TO_VAL_BASE, 32'd5000, q, e);
    host_u.xfer(1'b1, sai_pkg::CTRL, 32'h1, q, e);
    repeat (3) @(posedge pclk);
    chk("to_active", 32'h1, timeout_active);
    chk("to_user", sai_pkg::FS_Z25 / 2, dac_code[15:0]);
    host_u.xfer(1'b0, sai_pkg::CTRL, 32'h0, q, e);
    chk("ctrl_state", 32'h0000_000D, q);
    host_u.xfer(1'b1, sai_pkg::CH_CFG_BASE, 32'h0000_2C01, q, e);
    repeat (3) @(posedge pclk);
    chk("to_off_en", 32'h0, dac_enable[0]);
    chk("to_off_code", 32'h0, dac_code[15:0]);
    host_u.xfer(1'b1, sai_pkg::CH_CFG_BASE, 32'h0000_0C01, q, e);
    host_u.xfer(1'b1, sai_pkg::CTRL, 32'h3, q, e);
    host_u.xfer(1'b1, sai_pkg::OUT_SP_BASE, 32'd7000, q, e);
    repeat (3) @(posedge pclk);
    chk("run_code", 32'd7000, dac_code[15:0]);
    // Host falls silent: watchdog must trip
    repeat (60) @(posedge pclk);
    chk("wd_timeout", 32'h1, timeout_active);
    chk("to_hold", 32'd7000, dac_code[15:0]);
    host_u.xfer(1'b0, 12'hFFC, 32'h0, q, e);
    chk("unmapped", 32'h1, e);
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_rtd();
    t_cur();
    t_out();
    report_and_stop();
  end
endmodule
